// file: verilog/bcv_pkg.sv
// constants, types and decode helpers for the boot config vector capture
package bcv_pkg;
	localparam int unsigned CLK_MHZ = 20;
	// register byte offsets
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STS = 12'h004;
	localparam logic [11:0] ADDR_STATE = 12'h008;
	localparam logic [11:0] ADDR_MEM = 12'h100;
	localparam int unsigned MEM_DEPTH = 16;
	// control register bit positions
	localparam int unsigned CTRL_SWRST = 0;
	localparam int unsigned CTRL_HALT = 1;
	localparam int unsigned CTRL_CCDS = 2;
	localparam int unsigned CTRL_CCUS = 3;
	// reset procedure length
	localparam int unsigned INIT_TIME_NS = 800;
	localparam int unsigned INIT_CYCLES = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
	// decoded rates
	localparam logic [9:0] SMB_SLOW_KHZ = 10'h064;
	localparam logic [9:0] SMB_FAST_KHZ = 10'h190;
	localparam logic [7:0] REFCLK_LO_MHZ = 8'h64;
	localparam logic [7:0] REFCLK_HI_MHZ = 8'h7d;
	// switch operating mode codes
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_EEPROM = 4'h1;
	localparam logic [3:0] MODE_FO_P0 = 4'h8;
	localparam logic [3:0] MODE_FO_P2 = 4'h9;
	localparam logic [3:0] MODE_EE_FO_P0 = 4'ha;
	localparam logic [3:0] MODE_EE_FO_P2 = 4'hb;
	localparam logic [3:0] UP_PORT_0 = 4'h0;
	localparam logic [3:0] UP_PORT_2 = 4'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [3:0] switch_operating_mode;
		logic reset_halt;
		logic ref_clock_freq_select;
		logic [7:0] merge_pair;
		logic master_smbus_slow_select;
		logic common_clock_upstream;
		logic common_clock_downstream;
	} bcv_strap_s;

	typedef struct packed {
		logic common_clock_upstream;
		logic common_clock_downstream;
		logic reset_halt;
	} bcv_ovr_s;

	typedef struct packed {
		logic eeprom_init;
		logic failover;
		logic [3:0] up_port;
		logic reserved;
	} bcv_mode_s;

	typedef enum logic [3:0] {
		ST_RESET = 4'b0001,
		ST_INIT = 4'b0010,
		ST_HALT = 4'b0100,
		ST_RUN = 4'b1000
	} bcv_state_e;

	// switch operating mode decode
	function automatic bcv_mode_s decode_mode(input logic [3:0] m);
		bcv_mode_s r;
		r = '{eeprom_init: 1'b0, failover: 1'b0, up_port: UP_PORT_0,
			reserved: 1'b0};
		case (m)
			MODE_NORMAL: r.reserved = 1'b0;
			MODE_EEPROM: r.eeprom_init = 1'b1;
			MODE_FO_P0: r.failover = 1'b1;
			MODE_FO_P2:
			begin
				r.failover = 1'b1;
				r.up_port = UP_PORT_2;
			end
			MODE_EE_FO_P0:
			begin
				r.eeprom_init = 1'b1;
				r.failover = 1'b1;
			end
			MODE_EE_FO_P2:
			begin
				r.eeprom_init = 1'b1;
				r.failover = 1'b1;
				r.up_port = UP_PORT_2;
			end
			default: r.reserved = 1'b1;
		endcase
		return r;
	endfunction : decode_mode
endpackage : bcv_pkg

// file: verilog/bcv_cfg_mem.sv
// small byte-writable register memory with registered read data
`timescale 1ns/1ns
module bcv_cfg_mem #(
	parameter int unsigned DEPTH = 16,
	parameter int unsigned AW = 4
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [31:0] rdata_o
);
	logic [31:0] mem_q [DEPTH];

	// byte-lane write
	always_ff @(posedge clk_i)
	begin
		if (we_i)
		begin
			for (int b = 0; b < 4; b++)
			begin
				if (wstrb_i[b])
					mem_q[waddr_i][b*8 +: 8] <= wdata_i[b*8 +: 8];
			end
		end
	end

	// registered read port
	always_ff @(posedge clk_i)
	begin
		rdata_o <= mem_q[raddr_i];
	end
endmodule : bcv_cfg_mem

// file: verilog/bcv_top.sv
// boot config vector capture, reset sequencing and axi4-lite registers
`timescale 1ns/1ns
module bcv_top #(
	parameter int unsigned MEM_DEPTH = bcv_pkg::MEM_DEPTH,
	parameter int unsigned INIT_CYCLES = bcv_pkg::INIT_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic fundamental_reset_n_i,
	input wire bcv_pkg::bcv_strap_s strap_i,
	input wire logic ee_wr_i,
	input wire logic [11:0] ee_addr_i,
	input wire logic [31:0] ee_wdata_i,
	input wire logic ee_done_i,
	input wire logic [11:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [11:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic core_reset_n_o,
	output logic smbus_active_o,
	output logic common_clock_downstream_o,
	output logic common_clock_upstream_o,
	output logic [9:0] master_smbus_rate_khz_o,
	output logic [15:0] port_enable_o,
	output logic [15:0] port_x8_o,
	output logic [7:0] ref_clk_mhz_o,
	output logic eeprom_init_o,
	output logic failover_en_o,
	output logic [3:0] init_upstream_port_o,
	output logic mode_reserved_o
);
	localparam int unsigned MAW = $clog2(MEM_DEPTH);
	localparam logic [11:0] MEM_END = 12'(bcv_pkg::ADDR_MEM + 4 * MEM_DEPTH);

	logic rst_meta_q, rst_n;
	bcv_pkg::bcv_state_e st_q, st_d;
	logic pin_cause_q;
	logic cold_pend_q;
	bcv_pkg::bcv_strap_s strap_q, cold_sts_q, eff;
	bcv_pkg::bcv_ovr_s ovr_q;
	bcv_pkg::bcv_mode_s mode;
	logic [7:0] init_cnt_q;
	logic sw_rst_q;
	logic in_freset;
	logic aw_have_q, w_have_q, bvalid_q, awready_q, wready_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q;
	logic axi_wr, wr_en;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic aw_have_d, w_have_d, bvalid_d;
	logic rd_pend_q, arready_q, rvalid_q;
	logic [11:0] raddr_q;
	logic [31:0] rdata_q, mem_rdata;
	logic [1:0] rresp_q;

	function automatic logic is_mem(input logic [11:0] a);
		return (a >= bcv_pkg::ADDR_MEM) && (a < MEM_END);
	endfunction : is_mem

	function automatic logic [MAW-1:0] mem_idx(input logic [11:0] a);
		logic [11:0] off;
		off = a - bcv_pkg::ADDR_MEM;
		return off[MAW+1:2];
	endfunction : mem_idx

	// release of the asynchronous reset through two flops
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// effective settings: captured straps with overridable fields replaced
	always_comb
	begin
		eff = strap_q;
		eff.common_clock_downstream = ovr_q.common_clock_downstream;
		eff.common_clock_upstream = ovr_q.common_clock_upstream;
		eff.reset_halt = ovr_q.reset_halt;
		mode = bcv_pkg::decode_mode(strap_q.switch_operating_mode);
	end

	assign in_freset = (st_q == bcv_pkg::ST_INIT) || (st_q == bcv_pkg::ST_HALT);

	// reset sequence state
	always_comb
	begin
		st_d = st_q;
		case (st_q)
			bcv_pkg::ST_RESET:
				if (fundamental_reset_n_i)
					st_d = bcv_pkg::ST_INIT;
			bcv_pkg::ST_INIT:
				if (init_cnt_q == 8'(INIT_CYCLES - 1)
					&& (ee_done_i || !mode.eeprom_init))
					st_d = ovr_q.reset_halt ? bcv_pkg::ST_HALT
						: bcv_pkg::ST_RUN;
			bcv_pkg::ST_HALT:
				if (!ovr_q.reset_halt)
					st_d = bcv_pkg::ST_RUN;
			bcv_pkg::ST_RUN:
				if (sw_rst_q)
					st_d = bcv_pkg::ST_RESET;
			default: st_d = bcv_pkg::ST_RESET;
		endcase
		if (!fundamental_reset_n_i)
			st_d = bcv_pkg::ST_RESET;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			st_q <= bcv_pkg::ST_RESET;
		else
			st_q <= st_d;
	end

	// cause of the pending fundamental reset: pin or software
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			pin_cause_q <= 1'b1;
		else if (!fundamental_reset_n_i)
			pin_cause_q <= 1'b1;
		else if (st_q == bcv_pkg::ST_RUN && sw_rst_q)
			pin_cause_q <= 1'b0;
	end

	// reset procedure timer
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			init_cnt_q <= 8'h00;
		else if (st_q != bcv_pkg::ST_INIT)
			init_cnt_q <= 8'h00;
		else if (init_cnt_q != 8'(INIT_CYCLES - 1))
			init_cnt_q <= init_cnt_q + 8'h01;
	end

	// strap capture on pin negation; otherwise strap inputs are ignored
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			strap_q <= '0;
		else if (st_q == bcv_pkg::ST_RESET && fundamental_reset_n_i
			&& pin_cause_q)
			strap_q <= strap_i;
	end

	// status copy of the values sampled at the first pin negation after nrst_i release
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cold_pend_q <= 1'b1;
			cold_sts_q <= '0;
		end
		else if (st_q == bcv_pkg::ST_RESET && fundamental_reset_n_i
			&& pin_cause_q && cold_pend_q)
		begin
			cold_pend_q <= 1'b0;
			cold_sts_q <= strap_i;
		end
	end

	// overridable fields: loaded at reset exit, writable in reset only
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			ovr_q <= '0;
		else if (st_q == bcv_pkg::ST_RESET && fundamental_reset_n_i)
		begin
			ovr_q.common_clock_downstream <= pin_cause_q
				? strap_i.common_clock_downstream
				: strap_q.common_clock_downstream;
			ovr_q.common_clock_upstream <= pin_cause_q
				? strap_i.common_clock_upstream
				: strap_q.common_clock_upstream;
			ovr_q.reset_halt <= pin_cause_q ? strap_i.reset_halt
				: strap_q.reset_halt;
		end
		else if (wr_en && wr_addr == bcv_pkg::ADDR_CTRL && wr_strb[0]
			&& in_freset)
		begin
			ovr_q.reset_halt <= wr_data[bcv_pkg::CTRL_HALT];
			ovr_q.common_clock_downstream <= wr_data[bcv_pkg::CTRL_CCDS];
			ovr_q.common_clock_upstream <= wr_data[bcv_pkg::CTRL_CCUS];
		end
	end

	// software fundamental reset request, self clearing
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			sw_rst_q <= 1'b0;
		else
			sw_rst_q <= wr_en && wr_addr == bcv_pkg::ADDR_CTRL && wr_strb[0]
				&& wr_data[bcv_pkg::CTRL_SWRST] && st_q == bcv_pkg::ST_RUN;
	end

	// decoded settings, all registered
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			core_reset_n_o <= 1'b0;
			smbus_active_o <= 1'b0;
			common_clock_downstream_o <= 1'b0;
			common_clock_upstream_o <= 1'b0;
			master_smbus_rate_khz_o <= bcv_pkg::SMB_FAST_KHZ;
			ref_clk_mhz_o <= bcv_pkg::REFCLK_LO_MHZ;
			eeprom_init_o <= 1'b0;
			failover_en_o <= 1'b0;
			init_upstream_port_o <= bcv_pkg::UP_PORT_0;
			mode_reserved_o <= 1'b0;
		end
		else
		begin
			core_reset_n_o <= (st_q == bcv_pkg::ST_RUN);
			smbus_active_o <= (st_q != bcv_pkg::ST_RESET);
			common_clock_downstream_o <= eff.common_clock_downstream;
			common_clock_upstream_o <= eff.common_clock_upstream;
			master_smbus_rate_khz_o <= eff.master_smbus_slow_select
				? bcv_pkg::SMB_SLOW_KHZ : bcv_pkg::SMB_FAST_KHZ;
			ref_clk_mhz_o <= eff.ref_clock_freq_select
				? bcv_pkg::REFCLK_HI_MHZ : bcv_pkg::REFCLK_LO_MHZ;
			eeprom_init_o <= mode.eeprom_init;
			failover_en_o <= mode.failover;
			init_upstream_port_o <= mode.up_port;
			mode_reserved_o <= mode.reserved;
		end
	end

	// port pair merging: odd port folds in as lanes 4..7 of the even port
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			port_enable_o <= 16'hffff;
			port_x8_o <= 16'h0000;
		end
		else
		begin
			for (int k = 0; k < 8; k++)
			begin
				port_enable_o[2*k] <= 1'b1;
				port_enable_o[2*k+1] <= !eff.merge_pair[k];
				port_x8_o[2*k] <= eff.merge_pair[k];
				port_x8_o[2*k+1] <= 1'b0;
			end
		end
	end

	// register write source: eeprom loader wins, axi write waits
	always_comb
	begin
		axi_wr = aw_have_q && w_have_q && !bvalid_q && !ee_wr_i;
		wr_en = ee_wr_i || axi_wr;
		wr_addr = ee_wr_i ? ee_addr_i : awaddr_q;
		wr_data = ee_wr_i ? ee_wdata_i : wdata_q;
		wr_strb = ee_wr_i ? 4'hf : wstrb_q;
		aw_have_d = (aw_have_q && !axi_wr)
			|| (s_axi_awvalid_i && awready_q);
		w_have_d = (w_have_q && !axi_wr) || (s_axi_wvalid_i && wready_q);
		bvalid_d = (bvalid_q && !s_axi_bready_i) || axi_wr;
	end

	// axi write channels
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			bresp_q <= bcv_pkg::RESP_OKAY;
		end
		else
		begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			bvalid_q <= bvalid_d;
			awready_q <= !aw_have_d && !bvalid_d;
			wready_q <= !w_have_d && !bvalid_d;
			if (s_axi_awvalid_i && awready_q)
				awaddr_q <= {s_axi_awaddr_i[11:2], 2'b00};
			if (s_axi_wvalid_i && wready_q)
			begin
				wdata_q <= s_axi_wdata_i;
				wstrb_q <= s_axi_wstrb_i;
			end
			if (axi_wr)
				bresp_q <= (awaddr_q == bcv_pkg::ADDR_CTRL || is_mem(awaddr_q))
					? bcv_pkg::RESP_OKAY : bcv_pkg::RESP_SLVERR;
		end
	end

	bcv_cfg_mem #(
		.DEPTH(MEM_DEPTH),
		.AW(MAW)
	) u_mem (
		.clk_i(ref_clk_i),
		.we_i(wr_en && is_mem(wr_addr)),
		.waddr_i(mem_idx(wr_addr)),
		.wdata_i(wr_data),
		.wstrb_i(wr_strb),
		.raddr_i(mem_idx(s_axi_araddr_i)),
		.rdata_o(mem_rdata)
	);

	// axi read: address taken, one cycle for memory, then data
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_pend_q <= 1'b0;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			raddr_q <= 12'h000;
			rdata_q <= 32'h00000000;
			rresp_q <= bcv_pkg::RESP_OKAY;
		end
		else
		begin
			rd_pend_q <= s_axi_arvalid_i && arready_q;
			arready_q <= !(s_axi_arvalid_i && arready_q) && !rd_pend_q
				&& !(rvalid_q && !s_axi_rready_i);
			if (s_axi_arvalid_i && arready_q)
				raddr_q <= {s_axi_araddr_i[11:2], 2'b00};
			if (rd_pend_q)
			begin
				rvalid_q <= 1'b1;
				rresp_q <= bcv_pkg::RESP_OKAY;
				if (is_mem(raddr_q))
					rdata_q <= mem_rdata;
				else if (raddr_q == bcv_pkg::ADDR_CTRL)
					rdata_q <= {28'h0000000, ovr_q.common_clock_upstream,
						ovr_q.common_clock_downstream, ovr_q.reset_halt, 1'b0};
				else if (raddr_q == bcv_pkg::ADDR_STS)
					rdata_q <= {15'h0000, cold_sts_q};
				else if (raddr_q == bcv_pkg::ADDR_STATE)
					rdata_q <= {26'h0000000, cold_pend_q, pin_cause_q, st_q};
				else
				begin
					rdata_q <= 32'h00000000;
					rresp_q <= bcv_pkg::RESP_SLVERR;
				end
			end
			else if (s_axi_rready_i)
				rvalid_q <= 1'b0;
		end
	end

	assign s_axi_awready_o = awready_q;
	assign s_axi_wready_o = wready_q;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;
	assign s_axi_arready_o = arready_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rdata_o = rdata_q;
	assign s_axi_rresp_o = rresp_q;

	// checks
	sequence pin_release_s;
		st_q == bcv_pkg::ST_RESET && fundamental_reset_n_i && pin_cause_q;
	endsequence

	sequence sw_release_s;
		st_q == bcv_pkg::ST_RESET && fundamental_reset_n_i && !pin_cause_q;
	endsequence

	strap_capture_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		pin_release_s |=> strap_q == $past(strap_i))
		else $error("strap vector not captured at pin negation");
	strap_ignore_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		st_q != bcv_pkg::ST_RESET |=> $stable(strap_q))
		else $error("strap register changed outside reset");
	sw_reuse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		sw_release_s |=> $stable(strap_q) ##1 st_q == bcv_pkg::ST_INIT)
		else $error("software reset resampled straps");
	cold_status_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		!cold_pend_q |=> $stable(cold_sts_q))
		else $error("cold status changed after cold capture");
	override_gate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		st_q == bcv_pkg::ST_RUN |=> $stable(ovr_q))
		else $error("override bits changed in normal operation");
	halt_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		st_q == bcv_pkg::ST_HALT && ovr_q.reset_halt && fundamental_reset_n_i
		|=> st_q == bcv_pkg::ST_HALT ##1 !core_reset_n_o && smbus_active_o)
		else $error("halt state left while halt bit set");
	pin_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		!fundamental_reset_n_i |=> st_q == bcv_pkg::ST_RESET ##1 !core_reset_n_o)
		else $error("reset pin did not reset the core");
	smb_rate_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		##1 master_smbus_rate_khz_o == ($past(eff.master_smbus_slow_select)
		? bcv_pkg::SMB_SLOW_KHZ : bcv_pkg::SMB_FAST_KHZ))
		else $error("smbus rate does not follow slow select");
	refclk_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		##1 ref_clk_mhz_o == ($past(eff.ref_clock_freq_select)
		? bcv_pkg::REFCLK_HI_MHZ : bcv_pkg::REFCLK_LO_MHZ))
		else $error("reference clock decode wrong");
	merge_map_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		strap_q.merge_pair[0] && $stable(strap_q) |=> !port_enable_o[1]
		&& port_x8_o[0])
		else $error("merged pair 0/1 not folded");
	mode_fo_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		strap_q.switch_operating_mode == bcv_pkg::MODE_FO_P2 && $stable(strap_q)
		|=> failover_en_o && !eeprom_init_o
		&& init_upstream_port_o == bcv_pkg::UP_PORT_2)
		else $error("mode 0x9 decode wrong");
endmodule : bcv_top

// file: testbench/bcv_board.sv
// board model: strap pins and the fundamental reset pin
`timescale 1ns/1ns
module bcv_board (
	input wire logic clk_i,
	input wire logic go_i,
	input wire bcv_pkg::bcv_strap_s sv_i,
	output logic pin_n_o,
	output bcv_pkg::bcv_strap_s strap_o
);
	localparam logic [3:0] LOW_CYC = 4'h4;
	localparam logic [3:0] HOLD_CYC = 4'h4;
	logic [3:0] low_q = 4'h0;
	logic [3:0] hold_q = 4'h0;
	// pin stays asserted from power-up until the first pulse ends
	initial pin_n_o = 1'b0;
	initial strap_o = '0;
	// pulse the pin low, then churn the non-mode straps once hold runs out
	always @(posedge clk_i)
	begin
		if (go_i)
		begin
			pin_n_o <= 1'b0;
			low_q <= LOW_CYC;
			strap_o <= sv_i;
		end
		else if (low_q != 4'h0)
		begin
			low_q <= low_q - 4'h1;
			pin_n_o <= (low_q == 4'h1);
			hold_q <= HOLD_CYC;
		end
		else if (hold_q != 4'h0)
			hold_q <= hold_q - 4'h1;
		else
			strap_o[12:0] <= ~strap_o[12:0];
	end
endmodule : bcv_board

// file: testbench/testbench.sv
// self-checking bench for the boot config vector capture
`timescale 1ns/1ns
module testbench;
	localparam logic [60:0] ALL = '1;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic go = 1'b0;
	logic smp = 1'b0;
	logic ee_wr = 1'b0;
	logic ee_done = 1'b1;
	logic [11:0] ee_addr = 12'h000;
	logic [31:0] ee_wdata = 32'h0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, pin_n;
	logic core_n, smb, ccds, ccus, eei, foe, resv;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [9:0] rate;
	logic [15:0] pen, px8;
	logic [7:0] refm;
	logic [3:0] upp;
	logic [15:0] seed;
	logic [121:0] x;
	logic [60:0] e;
	bcv_pkg::bcv_strap_s sv = '0;
	bcv_pkg::bcv_strap_s strap, s, cold;
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	logic [121:0] oq[$];
	int n_mismatch = 0;
	int total_checks = 0;
	wire [60:0] obs = {core_n, smb, ccds, ccus, rate, pen, px8, refm, eei,
		foe, upp, resv};

	bcv_top #(.INIT_CYCLES(2)) dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.fundamental_reset_n_i(pin_n), .strap_i(strap), .ee_wr_i(ee_wr),
		.ee_addr_i(ee_addr), .ee_wdata_i(ee_wdata), .ee_done_i(ee_done),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .core_reset_n_o(core_n),
		.smbus_active_o(smb), .common_clock_downstream_o(ccds),
		.common_clock_upstream_o(ccus), .master_smbus_rate_khz_o(rate),
		.port_enable_o(pen), .port_x8_o(px8), .ref_clk_mhz_o(refm),
		.eeprom_init_o(eei), .failover_en_o(foe),
		.init_upstream_port_o(upp), .mode_reserved_o(resv));
	bcv_board board (.clk_i(ref_clk_i), .go_i(go), .sv_i(sv),
		.pin_n_o(pin_n), .strap_o(strap));

	// clock
	initial
	begin
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr

	// expected decode; ov is {upstream, downstream} common clock
	function automatic logic [60:0] expv(input bcv_pkg::bcv_strap_s t,
		input logic [1:0] ov);
		logic [15:0] pe;
		logic [15:0] pq;
		logic [3:0] m;
		pe = 16'hffff;
		pq = 16'h0000;
		m = t.switch_operating_mode;
		for (int k = 0; k < 8; k++)
		begin
			pe[2*k+1] = ~t.merge_pair[k];
			pq[2*k] = t.merge_pair[k];
		end
		return {2'b11, ov[0], ov[1],
			t.master_smbus_slow_select ? 10'h064 : 10'h190, pe, pq,
			t.ref_clock_freq_select ? 8'h7d : 8'h64,
			m inside {4'h1, 4'ha, 4'hb}, m inside {[4'h8:4'hb]},
			(m == 4'h9 || m == 4'hb) ? 4'h2 : 4'h0,
			m inside {[4'h2:4'h7], [4'hc:4'hf]}};
	endfunction : expv

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	task automatic note(input logic [60:0] v, input logic [60:0] msk);
		oq.push_back({msk, v});
		smp <= 1'b1;
		@(posedge ref_clk_i);
		smp <= 1'b0;
	endtask : note

	task automatic axw(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic fin;
		fin = 1'b0;
		bq.push_back(er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!fin)
		begin
			@(posedge ref_clk_i);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) fin = 1'b1;
		end
		bready <= 1'b0;
		@(posedge ref_clk_i);
	endtask : axw

	task automatic axr(input logic [11:0] a, input logic [33:0] er);
		logic fin;
		fin = 1'b0;
		rq.push_back(er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!fin)
		begin
			@(posedge ref_clk_i);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) fin = 1'b1;
		end
		rready <= 1'b0;
		@(posedge ref_clk_i);
	endtask : axr

	task automatic eew(input logic [11:0] a, input logic [31:0] d);
		ee_addr <= a;
		ee_wdata <= d;
		ee_wr <= 1'b1;
		@(posedge ref_clk_i);
		ee_wr <= 1'b0;
		@(posedge ref_clk_i);
	endtask : eew

	task automatic pick(input logic [3:0] m);
		seed = lfsr(seed);
		s = {m, 1'b0, seed[11:0]};
	endtask : pick

	task automatic wait_run(input int lim);
		int n;
		n = 0;
		while (core_n !== 1'b0 && n < 20)
		begin
			@(posedge ref_clk_i);
			n++;
		end
		n = 0;
		while (core_n !== 1'b1 && n < lim)
		begin
			@(posedge ref_clk_i);
			n++;
		end
		repeat (2) @(posedge ref_clk_i);
	endtask : wait_run

	task automatic boot;
		sv <= s;
		go <= 1'b1;
		@(posedge ref_clk_i);
		go <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		note(61'h0, {2'b11, 59'h0});
		wait_run(s.reset_halt ? 20 : 200);
	endtask : boot

	// result monitor: oldest note against what the outputs show
	always @(posedge ref_clk_i)
	begin
		if (bvalid && bready)
			chk({62'h0, bresp}, {62'h0, bq.pop_front()});
		if (rvalid && rready)
			chk({30'h0, rresp, rdata}, {30'h0, rq.pop_front()});
		if (smp)
		begin
			x = oq.pop_front();
			chk({3'h0, obs & x[121:61]}, {3'h0, x[60:0] & x[121:61]});
		end
	end

	// watchdog
	initial
	begin
		repeat (20000) @(posedge ref_clk_i);
		n_mismatch++;
		close_out();
	end

	// main sequence
	initial
	begin
		seed = 16'h0060;
		repeat (12) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		pick(4'h0);
		cold = s;
		boot();
		note(expv(s, {s.common_clock_upstream, s.common_clock_downstream}),
			ALL);
		repeat (20) @(posedge ref_clk_i);
		note(expv(s, {s.common_clock_upstream, s.common_clock_downstream}),
			ALL);
		axr(bcv_pkg::ADDR_STS, {bcv_pkg::RESP_OKAY, 15'h0, cold});
		$display("test cold capture done");
		for (int m = 0; m < 16; m++)
		begin
			pick(m[3:0]);
			ee_done <= (m != 1);
			boot();
			e = expv(s, {s.common_clock_upstream, s.common_clock_downstream});
			// eeprom mode must wait in reset until the load is done
			if (m == 1)
			begin
				e[60] = 1'b0;
				note(e, ALL);
				ee_done <= 1'b1;
				wait_run(50);
				e[60] = 1'b1;
			end
			note(e, ALL);
		end
		axr(bcv_pkg::ADDR_STS, {bcv_pkg::RESP_OKAY, 15'h0, cold});
		$display("test mode decode done");
		axw(bcv_pkg::ADDR_CTRL, 32'h1, bcv_pkg::RESP_OKAY);
		wait_run(200);
		note(e, ALL);
		$display("test software reset done");
		pick(4'h0);
		s.reset_halt = 1'b1;
		s[1:0] = 2'b00;
		boot();
		e = expv(s, 2'b00);
		e[60] = 1'b0;
		note(e, ALL);
		eew(bcv_pkg::ADDR_CTRL, 32'h6);
		repeat (2) @(posedge ref_clk_i);
		e[58] = 1'b1;
		note(e, ALL);
		axw(bcv_pkg::ADDR_CTRL, 32'hc, bcv_pkg::RESP_OKAY);
		wait_run(50);
		note(expv(s, 2'b11), ALL);
		$display("test reset halt done");
		axw(12'h100, 32'h5a3c_96e1, bcv_pkg::RESP_OKAY);
		axr(12'h100, {bcv_pkg::RESP_OKAY, 32'h5a3c_96e1});
		seed = lfsr(seed);
		eew(12'h13c, {seed, ~seed});
		axr(12'h13c, {bcv_pkg::RESP_OKAY, seed, ~seed});
		axw(12'h200, 32'h1, bcv_pkg::RESP_SLVERR);
		axr(12'h200, {bcv_pkg::RESP_SLVERR, 32'h0});
		axw(bcv_pkg::ADDR_STS, 32'h0, bcv_pkg::RESP_SLVERR);
		axr(bcv_pkg::ADDR_STS, {bcv_pkg::RESP_OKAY, 15'h0, cold});
		$display("test register access done");
		repeat (4) @(posedge ref_clk_i);
		close_out();
	end
endmodule : testbench
